// file: hw/sas_sequencer.v
// sas_sequencer.v: sar sequencer, flash encoder, coarse/fine merge, output latches
// assumes: comparator and trial dac outside; cmp input settles within the trial clock
`timescale 1ns/1ns
`include "sas_defs.vh"
module sas_sequencer #(
  parameter N = `SAS_RES_BITS,
  parameter NC = `SAS_COARSE_BITS,
  parameter NF = `SAS_FINE_BITS,
  parameter FLASH_CMPS = `SAS_FLASH_CMPS,
  parameter FIFO_DEPTH = `SAS_FIFO_DEPTH
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [1:0] mode_in,
  input wire sign_mag_in,
  input wire start_in,
  input wire cmp_above_in,
  input wire [FLASH_CMPS-1:0] flash_therm_in,
  input wire [FLASH_CMPS-1:0] fine_therm_in,
  input wire res_ready_in,
  output reg [N-1:0] dac_code_out,
  output reg cmp_latch_out,
  output reg busy_out,
  output reg done_out,
  output reg [N-1:0] result_out,
  output reg [N-1:0] magnitude_out,
  output reg sign_out,
  output reg res_valid_out,
  output reg [N:0] res_data_out,
  output reg overflow_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DECIDE = 3'h2;
  localparam ST_COARSE = 3'h3;
  localparam ST_FINE = 3'h4;
  localparam ST_FLASH = 3'h5;
  localparam ST_FINISH = 3'h6;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [N-1:0] sar_ff;
  reg [N-1:0] nxt_sar;
  reg [N-1:0] bit_ff;
  reg [N-1:0] nxt_bit;
  reg [N-1:0] raw_ff;
  reg [N-1:0] nxt_raw;
  reg [NC-1:0] coarse_ff;
  reg [NC-1:0] nxt_coarse;
  reg nxt_latch;
  reg nxt_finish;
  reg [N-1:0] merged;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [N:0] fifo_out_data;
  wire [N:0] fifo_word;
  wire [N-1:0] flash_cnt;
  wire [N-1:0] fine_cnt;
  wire take_start;
  wire out_pop;

  // thermometer to binary: count of set comparators, bubbles tolerated
  function [N-1:0] therm_count;
    input [FLASH_CMPS-1:0] t;
    integer i;
    begin
      therm_count = {N{1'b0}};
      for (i = 0; i < FLASH_CMPS; i = i + 1)
        if (t[i])
          therm_count = therm_count + 1'b1;
    end
  endfunction

  assign flash_cnt = therm_count(flash_therm_in);
  assign fine_cnt = therm_count(fine_therm_in);

  // sign bit is the msb of offset binary; magnitude folds around midscale
  function [N-1:0] fold_mag;
    input [N-1:0] code;
    begin
      if (code[N-1])
        fold_mag = {1'b0, code[N-2:0]};
      else
        fold_mag = {1'b0, ~code[N-2:0]};
    end
  endfunction

  // a new start waits for the result fifo so no result is dropped
  assign take_start = start_in && !busy_out && fifo_in_ready;

  always @* begin
    nxt_state = state_ff;
    nxt_sar = sar_ff;
    nxt_bit = bit_ff;
    nxt_raw = raw_ff;
    nxt_coarse = coarse_ff;
    nxt_latch = 1'b0;
    nxt_finish = 1'b0;
    merged = {N{1'b0}};
    case (state_ff)
      ST_IDLE: begin
        if (take_start) begin
          if (mode_in == `SAS_MODE_FLASH) begin
            nxt_state = ST_FLASH;
            nxt_latch = 1'b1;
          end else if (mode_in == `SAS_MODE_TWO_STAGE) begin
            nxt_state = ST_COARSE;
            nxt_latch = 1'b1;
          end else begin
            nxt_state = ST_DECIDE;
            nxt_sar = {1'b1, {(N-1){1'b0}}};
            nxt_bit = {1'b1, {(N-1){1'b0}}};
          end
        end
      end
      ST_DECIDE: begin
        // decision on the trial shown since the last edge, one bit per clock
        if (!cmp_above_in)
          nxt_sar = sar_ff & ~bit_ff;
        if (bit_ff[0]) begin
          nxt_state = ST_FINISH;
          nxt_raw = cmp_above_in ? sar_ff : (sar_ff & ~bit_ff);
          nxt_finish = 1'b1;
        end else begin
          nxt_bit = bit_ff >> 1;
          nxt_sar = (cmp_above_in ? sar_ff : (sar_ff & ~bit_ff)) | (bit_ff >> 1);
          nxt_state = ST_DECIDE;
        end
      end
      ST_COARSE: begin
        nxt_coarse = flash_cnt[NC-1:0];
        nxt_latch = 1'b1;
        nxt_state = ST_FINE;
      end
      ST_FINE: begin
        merged = {coarse_ff, fine_cnt[NF-1:0]};
        nxt_raw = merged;
        nxt_finish = 1'b1;
        nxt_state = ST_FINISH;
      end
      ST_FLASH: begin
        nxt_raw = flash_cnt;
        nxt_finish = 1'b1;
        nxt_state = ST_FINISH;
      end
      ST_FINISH: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  reg finish_ff;

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      sar_ff <= {N{1'b0}};
      bit_ff <= {N{1'b0}};
      raw_ff <= {N{1'b0}};
      coarse_ff <= {NC{1'b0}};
      finish_ff <= 1'b0;
      dac_code_out <= {N{1'b0}};
      cmp_latch_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sar_ff <= nxt_sar;
      bit_ff <= nxt_bit;
      raw_ff <= nxt_raw;
      coarse_ff <= nxt_coarse;
      finish_ff <= nxt_finish;
      dac_code_out <= nxt_sar;
      cmp_latch_out <= nxt_latch;
      busy_out <= (nxt_state != ST_IDLE);
    end
  end

  // all result bits updated in one edge and held until the next finish
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result_out <= {N{1'b0}};
      magnitude_out <= {N{1'b0}};
      sign_out <= 1'b0;
      done_out <= 1'b0;
      overflow_out <= 1'b0;
    end else begin
      done_out <= finish_ff;
      if (finish_ff) begin
        result_out <= raw_ff;
        magnitude_out <= fold_mag(raw_ff);
        sign_out <= raw_ff[N-1];
      end
      // start is gated on fifo room, so this only flags a broken guard
      if (finish_ff && !fifo_in_ready)
        overflow_out <= 1'b1;
    end
  end

  assign out_pop = !res_valid_out || res_ready_in;
  // pushed on the done edge, so a start in the done cycle sees the slot taken
  assign fifo_word = sign_mag_in ? {raw_ff[N-1], fold_mag(raw_ff)} : {1'b0, raw_ff};

  sas_fifo #(
    .WIDTH(N + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(finish_ff),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(out_pop),
    .out_data_out(fifo_out_data)
  );

  // output stage register keeps outputs straight from flops
  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      res_valid_out <= 1'b0;
      res_data_out <= {(N+1){1'b0}};
    end else if (out_pop) begin
      res_valid_out <= fifo_out_valid;
      if (fifo_out_valid)
        res_data_out <= fifo_out_data;
    end
  end
endmodule // sas_sequencer

// file: hw/sas_defs.vh
// sas_defs.vh: constants of the successive-approximation sequencer
// assumes: included by bare name from hw/ design files
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH
`define SAS_RES_BITS 8
`define SAS_COARSE_BITS 4
`define SAS_FINE_BITS 4
`define SAS_FIFO_DEPTH 8
`define SAS_MODE_SAR 2'h0
`define SAS_MODE_FLASH 2'h1
`define SAS_MODE_TWO_STAGE 2'h2
`define SAS_FLASH_CMPS 15
`endif

// file: hw/sas_fifo.v
// sas_fifo.v: small synchronous result fifo, valid/ready on both sides
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ns
module sas_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign in_ready_out = (count_ff != DEPTH[AW:0]);
  assign out_valid_out = (count_ff != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  function [AW-1:0] inc_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1 || DEPTH == (1 << AW) && (&p))
        inc_ptr = {AW{1'b0}};
      else
        inc_ptr = p + 1'b1;
    end
  endfunction

  always @(posedge sys_clk_in) begin
    if (push)
      mem[wr_ptr_ff] <= in_data_in;
  end

  always @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_ff <= inc_ptr(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= inc_ptr(rd_ptr_ff);
      if (push && !pop)
        count_ff <= count_ff + 1'b1;
      else if (pop && !push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule // sas_fifo

// file: testbench/sas_cmp_model.sv
// sas_cmp_model.sv: comparator, trial dac and flash stages
// assumes: bench gives the analogue level as an ideal 8-bit value
`timescale 1ns/1ns
module sas_cmp_model (
  input wire [7:0] vin_in,
  input wire [7:0] dac_code_in,
  output wire cmp_above_out,
  output wire [14:0] coarse_therm_out,
  output wire [14:0] fine_therm_out
);
  // the analogue level sits half a step above its code, so a tie counts as above
  assign cmp_above_out = vin_in >= dac_code_in;
  // level k sets the k lowest comparators
  assign coarse_therm_out = (15'h1 << vin_in[7:4]) - 15'h1;
  assign fine_therm_out = (15'h1 << vin_in[3:0]) - 15'h1;
endmodule // sas_cmp_model

// file: testbench/sas_seq_properties.sv
// sas_seq_properties.sv: port timing checks for the sequencer
// assumes: mode_in held steady through each conversion
`timescale 1ns/1ns
module sas_seq_props #(parameter N = 8) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire [1:0] mode_in,
  input wire cmp_above_in,
  input wire res_ready_in,
  input wire [N-1:0] dac_code_out,
  input wire cmp_latch_out,
  input wire busy_out,
  input wire done_out,
  input wire [N-1:0] result_out,
  input wire [N-1:0] magnitude_out,
  input wire sign_out,
  input wire res_valid_out,
  input wire [N:0] res_data_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // modes 0 and 3 run the sar
  a_start_msb: assert property ($rose(busy_out) && mode_in[0] == mode_in[1] |->
    dac_code_out == 1 << (N-1)) else $error("first trial not msb only");
  a_bit_decide: assert property ($rose(busy_out) && mode_in[0] == mode_in[1] |->
    ##1 dac_code_out[N-1:N-2] == {$past(cmp_above_in), 1'b1}) else $error("msb decision");
  // one clock per bit: done seen 9 after busy is seen
  a_sar_length: assert property ($rose(busy_out) && mode_in[0] == mode_in[1] |->
    (!done_out)[*8] ##1 !done_out ##1 done_out) else $error("sar length");
  a_flash_len: assert property ($rose(busy_out) && mode_in == 2'h1 |->
    cmp_latch_out ##2 done_out) else $error("flash length");
  a_two_stage: assert property ($rose(busy_out) && mode_in == 2'h2 |-> ##3 done_out)
    else $error("two-stage length");
  a_done_pulse: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not one cycle");
  a_result_hold: assert property (!done_out && $past(rst_n_in) |->
    $stable({result_out, magnitude_out, sign_out})) else $error("result moved without done");
  a_sign_msb: assert property (sign_out == result_out[N-1] && !magnitude_out[N-1])
    else $error("sign or magnitude msb");
  a_stream_hold: assert property (res_valid_out && !res_ready_in |=>
    res_valid_out && $stable(res_data_out)) else $error("stream word dropped");
endmodule // sas_seq_props
bind sas_sequencer sas_seq_props #(.N(N)) chk_u (.*);

// file: testbench/sas_sequencer_bench.sv
// sas_sequencer_bench.sv: self-checking bench for the sequencer
// assumes: hw/ design, partner model and checker compiled first
`timescale 1ns/1ns
module sas_sequencer_bench;
  logic sys_clk_in = 0, rst_n_in = 0, sign_mag_in = 0, start_in = 0, res_ready_in = 1;
  logic [1:0] mode_in = 0;
  logic [7:0] vin = 0;
  wire cmp_above, busy, done, res_valid, sign, ovf;
  wire [14:0] coarse, fine;
  wire [7:0] dac, result, mag;
  wire [8:0] res_data;
  int n_fail = 0, total_checks = 0, cyc = 0, i, k;
  logic [8:0] w;
  // mode, sign_mag, level, expected result
  logic [18:0] rows [9] = '{{2'h0, 1'h0, 8'h00, 8'h00}, {2'h0, 1'h0, 8'hff, 8'hff},
    {2'h0, 1'h0, 8'h80, 8'h80}, {2'h0, 1'h1, 8'h7f, 8'h7f}, {2'h3, 1'h0, 8'h5a, 8'h5a},
    {2'h2, 1'h0, 8'ha5, 8'ha5}, {2'h2, 1'h1, 8'h3c, 8'h3c}, {2'h2, 1'h0, 8'hf0, 8'hf0},
    {2'h1, 1'h0, 8'h90, 8'h09}}; // flash gives the count of set comparators
  sas_sequencer dut_u (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
    .sign_mag_in(sign_mag_in), .start_in(start_in), .cmp_above_in(cmp_above),
    .flash_therm_in(coarse), .fine_therm_in(fine), .res_ready_in(res_ready_in),
    .dac_code_out(dac), .cmp_latch_out(), .busy_out(busy), .done_out(done),
    .result_out(result), .magnitude_out(mag), .sign_out(sign), .res_valid_out(res_valid),
    .res_data_out(res_data), .overflow_out(ovf));
  sas_cmp_model cmp_u (.vin_in(vin), .dac_code_in(dac), .cmp_above_out(cmp_above),
    .coarse_therm_out(coarse), .fine_therm_out(fine));
  initial forever #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // sign is the offset-binary msb; magnitude folds around midscale
  function automatic logic [8:0] exp_word(input logic sm, input logic [7:0] c);
    if (!sm) return {1'b0, c};
    return {c[7], 1'b0, c[7] ? c[6:0] : ~c[6:0]};
  endfunction
  task automatic wait_sig(input bit on_done);
    k = 0;
    while ((on_done ? done : res_valid) !== 1'b1 && k < 40) begin
      @(negedge sys_clk_in);
      k++;
    end
  endtask
  // second request lands while busy and must be ignored
  task automatic conv(input logic [1:0] m, input logic sm, input logic [7:0] v);
    mode_in = m;
    sign_mag_in = sm;
    vin = v;
    start_in = 1;
    @(negedge sys_clk_in) start_in = 0;
    @(negedge sys_clk_in) start_in = 1;
    @(negedge sys_clk_in) start_in = 0;
    wait_sig(1);
    chk("done", 1, done);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk_in);
    rst_n_in = 1;
    for (i = 0; i < 9; i++) begin
      conv(rows[i][18:17], rows[i][16], rows[i][15:8]);
      w = exp_word(1'b1, rows[i][7:0]);
      chk("result", {1'b0, rows[i][7:0]}, {1'b0, result});
      chk("sign", {8'h00, w[8]}, {8'h00, sign});
      chk("magnitude", {1'b0, w[7:0]}, {1'b0, mag});
      @(negedge sys_clk_in);
      chk("busy", 0, busy);
      wait_sig(0);
      chk("res_valid", 1, res_valid);
      chk("word", exp_word(rows[i][16], rows[i][7:0]), res_data);
      @(negedge sys_clk_in);
    end
    // reset in mid-conversion clears everything
    mode_in = 2'h0;
    start_in = 1;
    @(negedge sys_clk_in) start_in = 0;
    repeat (4) @(negedge sys_clk_in);
    rst_n_in = 0;
    @(negedge sys_clk_in) rst_n_in = 1;
    chk("busy after reset", 0, busy);
    chk("result after reset", 0, {1'b0, result});
    chk("valid after reset", 0, res_valid);
    // stalled far side: output stage holds one word and the fifo eight more
    res_ready_in = 0;
    for (i = 0; i < 9; i++) conv(2'h0, 1'b0, 8'(8'h11 * i));
    start_in = 1;
    @(negedge sys_clk_in) start_in = 0;
    @(negedge sys_clk_in) chk("busy when full", 0, busy);
    res_ready_in = 1;
    for (i = 0; i < 9; i++) begin
      wait_sig(0);
      chk("drained word", {1'b0, 8'(8'h11 * i)}, res_data);
      @(negedge sys_clk_in);
    end
    repeat (3) @(negedge sys_clk_in);
    chk("empty", 0, res_valid);
    chk("overflow", 0, ovf);
    wrap_up();
  end
endmodule // sas_sequencer_bench
